//--- core/ecac_ctrl.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01: Address bits 15:12 read as zero.
// RULE_02: Twelve-bit linear byte address, software loads.
// RULE_03: Data register feeds writes, receives reads.
// RULE_04: Mode field picks atomic, erase, write.
// RULE_05: Mode writes ignored while strobe set.
// RULE_06: Reset clears mode unless programming.
// RULE_07: Ready interrupt holds while strobe clear.
// RULE_08: Master enable clears four cycles later.
// RULE_09: Strobe starts write only with enable.
// RULE_10: Software sequence: wait, load, enable, strobe.
// RULE_11: Software checks flash programming finished first.
// RULE_12: Hardware clears strobe when write done.
// RULE_13: Programming strobe stalls CPU two cycles.
// RULE_14: Read strobe fetches byte, stalls four.
// RULE_15: Programming blocks reads and address changes.
// RULE_16: Write timed by 26,368 oscillator cycles; the code does so in atomic mode only, erase and write modes count 13,959.
// RULE_17: Software keeps interrupts off during sequence.
// RULE_18: Control bits 7:6 read as zero.
// RULE_19: Reset does not abort a write.
// RULE_20: Software zero never clears the strobe.
module ecac_ctrl
    import ecac_pkg::*;
#(
    parameter int RC_ATOMIC_CYC = ecac_pkg::RC_ATOMIC_CYC_DEF
) (
    // Clock, system reset and power-on reset.
    input wire logic CLK,
    input wire logic RST,
    input wire logic POR,
    // I/O register port.
    input wire logic [ecac_pkg::IO_ADDR_W-1:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic [ecac_pkg::DATA_W-1:0] IO_WDATA,
    output logic [ecac_pkg::DATA_W-1:0] IO_RDATA,
    // CPU side signals.
    input wire logic GLOBAL_IE,
    output logic READY_IRQ,
    output logic CPU_STALL,
    // Calibrated oscillator pin.
    input wire logic RC_OSC
);
    import ecac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Derived constants.

    // Split modes take the shorter time in proportion.
    localparam int RC_SPLIT_CYC = (RC_ATOMIC_CYC * T_SPLIT_US) / T_ATOMIC_US;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Byte address.
    logic [ADDR_W-1:0] nv_byte_address_q, nv_byte_address_d;
    // Data register.
    logic [DATA_W-1:0] nv_data_reg_q, nv_data_reg_d;
    // Programming mode field.
    ecac_mode_t program_mode_field_q, program_mode_field_d;
    // Ready interrupt enable.
    logic ready_irq_enable_q, ready_irq_enable_d;
    // Master enable window counter; the bit reads as one while non-zero.
    logic [MPE_W-1:0] mpe_cnt_q, mpe_cnt_d;
    // CPU stall counter.
    logic [STALL_W-1:0] stall_q, stall_d;
    // Engine state; busy is the programming strobe as software sees it.
    ecac_state_t state_q, state_d;
    // Address, data and mode latched at the start of a write.
    logic [ADDR_W-1:0] lat_addr_q;
    logic [DATA_W-1:0] lat_data_q;
    ecac_mode_t lat_mode_q;
    // Registered read data.
    logic [DATA_W-1:0] rdata_q, rdata_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    // Write strobes per register.
    wire wr_ctrl = IO_WR && (IO_ADDR == OFS_CONTROL);
    wire wr_data = IO_WR && (IO_ADDR == OFS_DATA);
    wire wr_low = IO_WR && (IO_ADDR == OFS_ADDR_LOW);
    wire wr_high = IO_WR && (IO_ADDR == OFS_ADDR_HIGH);
    // Programming in progress.
    wire busy = (state_q == ST_BUSY);
    // Master enable as software sees it.
    wire mpe_on = (mpe_cnt_q != '0);
    // Software sets the master enable.
    wire wr_mpe = wr_ctrl && IO_WDATA[BIT_MASTER_ENABLE];
    // Only a written one with the enable still open starts a write; a zero does nothing.
    // RULE_09: enable gates start.
    // RULE_20: zero is ignored.
    wire start = wr_ctrl && IO_WDATA[BIT_PROGRAM_STROBE] && mpe_on && !busy
        && (program_mode_field_q != MODE_RESERVED);
    // Read strobe is refused while programming.
    // RULE_15: reads blocked.
    wire rd_go = wr_ctrl && IO_WDATA[BIT_READ_STROBE] && !busy;
    // Control register as read back; bits 7:6 stay zero.
    // RULE_18: reserved reads zero.
    wire [DATA_W-1:0] ctrl_view = {2'b00, program_mode_field_q, ready_irq_enable_q,
        mpe_on, busy, 1'b0};
    // Byte fetched from the array.
    wire [DATA_W-1:0] mem_rdata;
    // Timer completion.
    wire tmr_done;
    // Oscillator cycles for the mode in hand.
    // RULE_16: count per mode.
    wire [RC_CNT_W-1:0] tmr_count = (program_mode_field_q == MODE_ATOMIC) ?
        RC_CNT_W'(RC_ATOMIC_CYC) : RC_CNT_W'(RC_SPLIT_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Software-visible registers.

    // Next values of address, data, enable and mode.
    always_comb begin
        nv_byte_address_d = nv_byte_address_q;
        nv_data_reg_d = nv_data_reg_q;
        ready_irq_enable_d = ready_irq_enable_q;
        program_mode_field_d = program_mode_field_q;
        // Address bytes are taken only while idle.
        // RULE_02: twelve-bit address.
        // RULE_15: address locked.
        if (wr_low && !busy) begin
            nv_byte_address_d[7:0] = IO_WDATA;
        end
        if (wr_high && !busy) begin
            nv_byte_address_d[ADDR_W-1:8] = IO_WDATA[ADDR_W-9:0];
        end
        // A read loads the fetched byte; software writes load the byte to program.
        // RULE_03: data register path.
        // RULE_14: fetch in one step.
        if (rd_go) begin
            nv_data_reg_d = mem_rdata;
        end else if (wr_data) begin
            nv_data_reg_d = IO_WDATA;
        end
        if (wr_ctrl) begin
            ready_irq_enable_d = IO_WDATA[BIT_READY_IRQ_EN];
        end
        // Mode writes are dropped while the strobe is set.
        // RULE_05: mode frozen.
        if (wr_ctrl && !busy) begin
            program_mode_field_d = ecac_mode_t'(IO_WDATA[BIT_MODE_HI:BIT_MODE_LO]);
        end
        // System reset clears the mode only when no write is running.
        // RULE_06: conditional mode reset.
        if (RST && !busy) begin
            program_mode_field_d = MODE_ATOMIC;
        end
    end

    // Master enable window and CPU stall counters.
    always_comb begin
        mpe_cnt_d = mpe_cnt_q;
        stall_d = stall_q;
        // RULE_08: enable times out.
        if (wr_mpe) begin
            mpe_cnt_d = MPE_WINDOW_CYC;
        end else if (mpe_on) begin
            mpe_cnt_d = mpe_cnt_q - MPE_W'(1);
        end
        // RULE_13: write stall.
        // RULE_14: read stall.
        if (start) begin
            stall_d = WRITE_STALL_CYC;
        end else if (rd_go) begin
            stall_d = READ_STALL_CYC;
        end else if (stall_q != '0) begin
            stall_d = stall_q - STALL_W'(1);
        end
    end

    // Register read selection; unmapped addresses read zero.
    // RULE_01: high nibble zero.
    always_comb begin
        case (IO_ADDR)
            OFS_CONTROL: rdata_d = ctrl_view;
            OFS_DATA: rdata_d = nv_data_reg_q;
            OFS_ADDR_LOW: rdata_d = nv_byte_address_q[7:0];
            OFS_ADDR_HIGH: rdata_d = {4'h0, nv_byte_address_q[ADDR_W-1:8]};
            default: rdata_d = 8'h00;
        endcase
    end

    // Registers cleared by the system reset.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            nv_byte_address_q <= ADDR_RESET;
            nv_data_reg_q <= DATA_RESET;
            ready_irq_enable_q <= 1'b0;
            mpe_cnt_q <= '0;
            stall_q <= '0;
            rdata_q <= 8'h00;
        end else begin
            nv_byte_address_q <= nv_byte_address_d;
            nv_data_reg_q <= nv_data_reg_d;
            ready_irq_enable_q <= ready_irq_enable_d;
            mpe_cnt_q <= mpe_cnt_d;
            stall_q <= stall_d;
            rdata_q <= rdata_d;
        end
    end

    // Mode field is cleared asynchronously only at power-on.
    always_ff @(posedge CLK or posedge POR) begin
        if (POR) begin
            program_mode_field_q <= MODE_ATOMIC;
        end else begin
            program_mode_field_q <= program_mode_field_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Programming engine.

    // Leaves busy when the timer runs out, which clears the strobe.
    // RULE_12: self-clearing strobe.
    always_comb begin
        case (state_q)
            ST_IDLE: state_d = start ? ST_BUSY : ST_IDLE;
            ST_BUSY: state_d = tmr_done ? ST_IDLE : ST_BUSY;
            default: state_d = ST_IDLE;
        endcase
    end

    // Engine state survives the system reset so a running write completes.
    // RULE_19: write carried through.
    always_ff @(posedge CLK or posedge POR) begin
        if (POR) begin
            state_q <= ST_IDLE;
            lat_addr_q <= ADDR_RESET;
            lat_data_q <= DATA_RESET;
            lat_mode_q <= MODE_ATOMIC;
        end else begin
            state_q <= state_d;
            if (start) begin
                lat_addr_q <= nv_byte_address_q;
                lat_data_q <= nv_data_reg_q;
                lat_mode_q <= program_mode_field_q;
            end
        end
    end

    // Oscillator-timed delay of each write.
    ecac_rc_timer #(
        .CW(RC_CNT_W)
    ) u_timer (
        .clk(CLK),
        .por(POR),
        .rc_osc(RC_OSC),
        .start(start),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Byte array.
    ecac_nv_array #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_array (
        .clk(CLK),
        .rd_addr(nv_byte_address_q),
        .rd_data(mem_rdata),
        .wr_en(busy && tmr_done),
        .wr_addr(lat_addr_q),
        .wr_mode(lat_mode_q),
        .wr_data(lat_data_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Ready interrupt is a level that stands while the strobe is clear.
    // RULE_07: ready interrupt level.
    assign READY_IRQ = ready_irq_enable_q && GLOBAL_IE && !busy;
    assign CPU_STALL = (stall_q != '0);
    assign IO_RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    addr_high_rsvd_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_01
        ($past(IO_ADDR) == OFS_ADDR_HIGH) |-> (IO_RDATA[7:4] == 4'h0))
        else $error("Reserved address bits read non-zero.");
    ctrl_rsvd_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_18
        ($past(IO_ADDR) == OFS_CONTROL) |-> (IO_RDATA[7:6] == 2'b00))
        else $error("Reserved control bits read non-zero.");
    mpe_window_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_08
        wr_mpe ##1 (!wr_mpe)[*4] |=> !mpe_on)
        else $error("Master enable did not clear after four cycles.");
    mpe_hold_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_08
        wr_mpe |=> mpe_on[*4])
        else $error("Master enable dropped too early.");
    start_gate_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_09
        $rose(busy) |-> $past(mpe_on))
        else $error("Write started without master enable.");
    mode_frozen_a: assert property (@(posedge CLK) disable iff (POR) // RULE_05
        busy |=> $stable(program_mode_field_q))
        else $error("Mode field changed during programming.");
    mode_reset_a: assert property (@(posedge CLK) disable iff (POR) // RULE_06
        (RST && !busy) |=> (program_mode_field_q == MODE_ATOMIC))
        else $error("Mode field not cleared by reset.");
    irq_busy_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_07
        busy |-> !READY_IRQ)
        else $error("Ready interrupt during programming.");
    write_stall_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_13
        start |=> CPU_STALL[*2] ##1 !CPU_STALL)
        else $error("Write stall not two cycles.");
    read_stall_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_14
        (rd_go && !start) |=> CPU_STALL[*4] ##1 !CPU_STALL)
        else $error("Read stall not four cycles.");
    read_data_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_03
        rd_go |=> (nv_data_reg_q == $past(mem_rdata)))
        else $error("Read did not load the data register.");
    addr_lock_a: assert property (@(posedge CLK) disable iff (RST || POR) // RULE_15
        busy |=> $stable(nv_byte_address_q))
        else $error("Address changed during programming.");
    strobe_clear_a: assert property (@(posedge CLK) disable iff (POR) // RULE_12
        (busy && tmr_done) |=> !busy)
        else $error("Strobe not cleared at end of write.");

endmodule

//--- core/ecac_pkg.sv
package ecac_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths.

    // Width of the byte address into the nonvolatile array.
    localparam int ADDR_W = 12;
    // Width of one stored byte.
    localparam int DATA_W = 8;
    // Width of the I/O register address.
    localparam int IO_ADDR_W = 6;
    // Width of the oscillator cycle counter.
    localparam int RC_CNT_W = 15;
    // Width of the CPU stall counter.
    localparam int STALL_W = 3;
    // Width of the master enable window counter.
    localparam int MPE_W = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets in I/O space.

    // Control register.
    localparam logic [5:0] OFS_CONTROL = 6'h1f;
    // Data register.
    localparam logic [5:0] OFS_DATA = 6'h20;
    // Address register, low byte.
    localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
    // Address register, high byte.
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register bit positions.

    // Read strobe.
    localparam int BIT_READ_STROBE = 0;
    // Programming strobe.
    localparam int BIT_PROGRAM_STROBE = 1;
    // Master programming enable.
    localparam int BIT_MASTER_ENABLE = 2;
    // Ready interrupt enable.
    localparam int BIT_READY_IRQ_EN = 3;
    // Programming mode field, low and high bit.
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_MODE_HI = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.

    // Address and data registers after reset.
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Value of an erased byte.
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.

    // Master enable window and CPU stall lengths, in CPU clock cycles.
    localparam logic [2:0] MPE_WINDOW_CYC = 3'h4;
    localparam logic [2:0] WRITE_STALL_CYC = 3'h2;
    localparam logic [2:0] READ_STALL_CYC = 3'h4;
    // Programming times per mode, in microseconds.
    localparam int T_ATOMIC_US = 3400;
    localparam int T_SPLIT_US = 1800;
    // Oscillator cycles for a CPU-started atomic write.
    localparam int RC_ATOMIC_CYC_DEF = 26368;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.

    // Programming modes.
    typedef enum logic [1:0] {
        MODE_ATOMIC = 2'b00,
        MODE_ERASE = 2'b01,
        MODE_WRITE = 2'b10,
        MODE_RESERVED = 2'b11
    } ecac_mode_t;

    // Programming engine states.
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } ecac_state_t;

endpackage

//--- core/ecac_nv_array.sv
`timescale 1ns/1ps

module ecac_nv_array
    import ecac_pkg::*;
#(
    parameter int AW = ecac_pkg::ADDR_W,
    parameter int DW = ecac_pkg::DATA_W
) (
    // Clock.
    input wire logic clk,
    // Read port.
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data,
    // Commit port.
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire ecac_pkg::ecac_mode_t wr_mode,
    input wire logic [DW-1:0] wr_data
);
    import ecac_pkg::*;

    // The byte array itself; contents survive every reset.
    logic [DW-1:0] mem [0:(1<<AW)-1];
    // Byte currently stored at the commit address.
    wire [DW-1:0] old_byte = mem[wr_addr];
    // Value that the selected mode leaves behind.
    logic [DW-1:0] new_byte;

    // Reads are combinational so a fetch completes in one instruction.
    assign rd_data = mem[rd_addr];

    // Chooses the result of each programming mode.
    // RULE_04: mode selects action.
    always_comb begin
        case (wr_mode)
            MODE_ATOMIC: new_byte = wr_data;
            MODE_ERASE: new_byte = ERASED_BYTE;
            MODE_WRITE: new_byte = old_byte & wr_data;
            default: new_byte = old_byte;
        endcase
    end

    // Stores the result when the timed operation finishes.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= new_byte;
        end
    end

endmodule

//--- core/ecac_rc_timer.sv
`timescale 1ns/1ps

module ecac_rc_timer
    import ecac_pkg::*;
#(
    parameter int CW = ecac_pkg::RC_CNT_W
) (
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic por,
    // Oscillator pin.
    input wire logic rc_osc,
    // Start request with its cycle count.
    input wire logic start,
    input wire logic [CW-1:0] count,
    // One-cycle pulse when the count has run out.
    output logic done
);
    import ecac_pkg::*;

    // Three-stage synchroniser for the oscillator.
    logic sync1_q, sync2_q, sync3_q;
    // Remaining oscillator cycles.
    logic [CW-1:0] cnt_q, cnt_d;
    // Counter is running.
    logic run_q, run_d;
    // Oscillator level as last agreed by stages two and three.
    logic lvl_q;
    // The agreed level follows stage three only while stages two and three match.
    wire lvl_d = (sync2_q == sync3_q) ? sync3_q : lvl_q;
    // A rising edge counts once stages two and three agree on a new high level.
    wire rc_edge = sync2_q & sync3_q & ~lvl_q;
    // Last oscillator cycle seen.
    wire last = run_q & rc_edge & (cnt_q == CW'(1));

    // Next state of the down counter.
    // RULE_16: timed from oscillator.
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (start) begin
            cnt_d = count;
            run_d = 1'b1;
        end else if (last) begin
            cnt_d = '0;
            run_d = 1'b0;
        end else if (run_q & rc_edge) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    // Only power-on clears the timer, so a system reset never cuts a write short.
    // RULE_19: survive system reset.
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            lvl_q <= 1'b0;
            cnt_q <= '0;
            run_q <= 1'b0;
        end else begin
            sync1_q <= rc_osc;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    // Completion pulse.
    assign done = last;

endmodule

//--- sim/test_eeprom_cpu_access_ctrl.sv
`timescale 1ns/1ps

module test_eeprom_cpu_access_ctrl;
    import ecac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Shortened oscillator count; the split modes take the scaled share of it.
    localparam int RC_N = 20;
    localparam int RC_SPLIT = RC_N * 1800 / 3400;

    // Clocks, resets and register port.
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic POR = 1'b1;
    logic [5:0] IO_ADDR = 6'h00;
    logic IO_WR = 1'b0;
    logic [7:0] IO_WDATA = 8'h00;
    logic [7:0] IO_RDATA;
    logic GLOBAL_IE = 1'b0;
    logic READY_IRQ;
    logic CPU_STALL;
    logic RC_OSC = 1'b0;
    // Bench bookkeeping.
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    // Cycle count taken just after the programming strobe was written.
    int t_go = 0;
    logic [7:0] rv;
    logic first_stall;

    // The CPU clock, and an oscillator four clock periods long that flips on falling edges.
    always #20 CLK = ~CLK;
    always #80 RC_OSC = ~RC_OSC;
    // Free cycle count used to time programming.
    always @(posedge CLK) cyc <= cyc + 1;

    ecac_ctrl #(.RC_ATOMIC_CYC(RC_N)) uut (
        .CLK(CLK), .RST(RST), .POR(POR), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_WDATA(IO_WDATA),
        .IO_RDATA(IO_RDATA), .GLOBAL_IE(GLOBAL_IE), .READY_IRQ(READY_IRQ), .CPU_STALL(CPU_STALL),
        .RC_OSC(RC_OSC)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register write; an idle cycle follows so the strobe is never set twice in a step.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        IO_ADDR = a;
        IO_WDATA = d;
        IO_WR = 1'b1;
        @(negedge CLK);
        IO_WR = 1'b0;
        first_stall = CPU_STALL;
        @(negedge CLK);
    endtask

    // One register read; the data is registered, so it is taken a cycle later.
    task automatic rd(input logic [5:0] a);
        IO_ADDR = a;
        @(negedge CLK);
        rv = IO_RDATA;
    endtask

    // Counts the stall cycles after the last write, including the one inside wr.
    task automatic count_stall(input int exp);
        int n;
        n = int'(first_stall === 1'b1);
        while (CPU_STALL === 1'b1 && n < 10) begin
            n++;
            @(negedge CLK);
        end
        chk(16'(n), 16'(exp));
    endtask

    // Master enable, optional idle cycles, then the strobe; ready enable kept on.
    // The start time is kept so the completion check measures from the strobe.
    task automatic prog(input logic [1:0] m, input logic [7:0] d, input int idle);
        wr(OFS_DATA, d);
        wr(OFS_CONTROL, {2'b00, m, 4'hc});
        repeat (idle) @(negedge CLK);
        wr(OFS_CONTROL, {2'b00, m, 4'ha});
        t_go = cyc;
    endtask

    // Polls the strobe until it clears, then checks the time since the strobe was set.
    task automatic wait_done(input int n);
        int el;
        for (int i = 0; i < 1000; i++) begin
            rd(OFS_CONTROL);
            if (rv[1] === 1'b0) begin
                break;
            end
        end
        if (rv[1] !== 1'b0) begin
            miscompares++;
            tally_and_finish();
        end
        el = cyc - t_go + 2;
        chk(16'((el >= 4 * n - 4) && (el <= 4 * n + 12)), 16'h1);
    endtask

    // Fetches the addressed byte and compares it.
    task automatic rd_byte(input logic [7:0] exp);
        wr(OFS_CONTROL, 8'h01);
        count_stall(4);
        rd(OFS_DATA);
        chk(rv, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reserved bits, interrupt level and the master enable window.
    task automatic s_regs;
        rd(OFS_CONTROL);
        chk(rv, 8'h00);
        wr(OFS_ADDR_HIGH, 8'hff);
        rd(OFS_ADDR_HIGH);
        chk(rv, 8'h0f);
        wr(OFS_ADDR_LOW, 8'hff);
        rd(OFS_ADDR_LOW);
        chk(rv, 8'hff);
        wr(OFS_CONTROL, 8'hc8);
        rd(OFS_CONTROL);
        chk(rv, 8'h08);
        GLOBAL_IE = 1'b1;
        @(negedge CLK);
        chk(READY_IRQ, 1'b1);
        wr(OFS_CONTROL, 8'h00);
        chk(READY_IRQ, 1'b0);
        GLOBAL_IE = 1'b0;
        rd(6'h10);
        chk(rv, 8'h00);
        // The enable stays three more cycles after wr returns, then drops.
        wr(OFS_CONTROL, 8'h04);
        repeat (3) begin
            rd(OFS_CONTROL);
            chk(rv, 8'h04);
        end
        rd(OFS_CONTROL);
        chk(rv, 8'h00);
        wr(OFS_CONTROL, 8'h02);
        count_stall(0);
        rd(OFS_CONTROL);
        chk(rv, 8'h00);
    endtask

    // Atomic write with refused accesses while it runs.
    task automatic s_atomic;
        wr(OFS_ADDR_LOW, 8'ha5);
        wr(OFS_ADDR_HIGH, 8'h05);
        GLOBAL_IE = 1'b1;
        prog(2'b00, 8'h3c, 0);
        count_stall(2);
        chk(READY_IRQ, 1'b0);
        wr(OFS_ADDR_LOW, 8'h00);
        rd(OFS_ADDR_LOW);
        chk(rv, 8'ha5);
        wr(OFS_DATA, 8'h77);
        wr(OFS_CONTROL, 8'h3b);
        rd(OFS_CONTROL);
        chk(rv, 8'h0a);
        rd(OFS_DATA);
        chk(rv, 8'h77);
        wr(OFS_CONTROL, 8'h08);
        rd(OFS_CONTROL);
        chk(rv, 8'h0a);
        wait_done(RC_N);
        chk(READY_IRQ, 1'b1);
        GLOBAL_IE = 1'b0;
        rd_byte(8'h3c);
    endtask

    // Split modes at the same byte; erase starts on the last cycle of the window.
    task automatic s_modes;
        logic [1:0] md [3] = '{2'b01, 2'b10, 2'b10};
        logic [7:0] dv [3] = '{8'h00, 8'h5a, 8'h0f};
        logic [7:0] ev [3] = '{8'hff, 8'h5a, 8'h0a};
        for (int i = 0; i < 3; i++) begin
            prog(md[i], dv[i], (i == 0) ? 2 : 0);
            wait_done(RC_SPLIT);
            rd_byte(ev[i]);
        end
        prog(2'b11, 8'h00, 0);
        rd(OFS_CONTROL);
        chk(rv[1], 1'b0);
    endtask

    // Reset during an erase keeps the mode and lets it finish.
    task automatic s_reset;
        wr(OFS_ADDR_LOW, 8'hff);
        wr(OFS_ADDR_HIGH, 8'h0f);
        prog(2'b01, 8'h00, 0);
        RST = 1'b1;
        @(negedge CLK);
        RST = 1'b0;
        rd(OFS_CONTROL);
        chk(rv, 8'h12);
        wait_done(RC_SPLIT);
        RST = 1'b1;
        @(negedge CLK);
        RST = 1'b0;
        rd(OFS_CONTROL);
        chk(rv, 8'h00);
        wr(OFS_ADDR_LOW, 8'hff);
        wr(OFS_ADDR_HIGH, 8'h0f);
        rd_byte(8'hff);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: both resets for three cycles, then the scenarios.
    initial begin
        repeat (3) @(negedge CLK);
        RST = 1'b0;
        POR = 1'b0;
        s_regs();
        s_atomic();
        s_modes();
        s_reset();
        tally_and_finish();
    end

endmodule
